/* hw/psf_top.sv */
/*
  Single-pin serial byte receiver/transmitter with a flash range read-back engine,
  reached over AXI4-Lite. Assumes a flash read port that returns data in the same clock
  as the read strobe, and an open-drain pin with an external pullup.
*/
`default_nettype none
module psf_top #(
  parameter int BIT_DIV = psf_pkg::BIT_DIV
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [psf_pkg::AXI_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [psf_pkg::AXI_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_serial_pin,
  output logic o_serial_pin,
  output logic o_serial_pin_oe,
  output logic [15:0] o_flash_addr,
  output logic o_flash_rd,
  input wire logic [7:0] i_flash_data,
  output logic o_watchdog_service
);
  import psf_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_RX = 3'b001,
    M_TX = 3'b010,
    M_VREAD = 3'b011,
    M_VCHECK = 3'b100,
    M_VSEND = 3'b101
  } psf_mode_t;

  typedef struct packed {
    psf_mode_t mode;
    logic [7:0] acc;
    logic [15:0] index;
    logic [15:0] last;
    logic [7:0] buf_base;
    logic [7:0] buf_ptr;
    logic [7:0] offset;
    logic [7:0] sum;
    logic carry;
    logic frame_err;
    logic done;
    logic send_opt;
    logic at_last;
    logic flash_rd;
    logic [4:0] wd_cnt;
    logic wd_first_done;
    logic wd_pulse;
    logic rx_go;
    logic tx_go;
    logic [7:0] tx_byte;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psf_regs_t;

  psf_regs_t q_ff;
  psf_regs_t nxt_q;
  logic [7:0] cmp_buf [0:255];
  logic buf_we;
  logic [7:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic [7:0] cmp_idx;
  logic char_done;
  logic [7:0] char_byte;
  logic char_stop_ok;
  logic char_drive_low;
  logic wr_fire;
  logic [31:0] wr_val;
  logic [7:0] wr_addr;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic busy;

  psf_char #(
    .BIT_DIV(BIT_DIV)
  ) u_char (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_rx_go(q_ff.rx_go),
    .i_tx_go(q_ff.tx_go),
    .i_tx_byte(q_ff.tx_byte),
    .i_pin(i_serial_pin),
    .o_done(char_done),
    .o_byte(char_byte),
    .o_stop_ok(char_stop_ok),
    .o_drive_low(char_drive_low)
  );

  // Compare entries sit in the zero page, so the index wraps within 256 bytes.
  assign cmp_idx = q_ff.buf_base + q_ff.offset;
  assign busy = (q_ff.mode != M_IDLE);

  always_comb
  begin
    wr_val = q_ff.wdata;
    wr_addr = q_ff.aw_addr;
    wr_fire = q_ff.aw_held && q_ff.w_held && !q_ff.bvalid;
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (i_araddr == OFS_CTRL)
    begin
      rd_val = 32'h0000_0000;
    end
    else if (i_araddr == OFS_STATUS)
    begin
      rd_val[ST_BUSY_BIT] = busy;
      rd_val[ST_CARRY_BIT] = q_ff.carry;
      rd_val[ST_FRAME_BIT] = q_ff.frame_err;
      rd_val[ST_DONE_BIT] = q_ff.done;
    end
    else if (i_araddr == OFS_ACC)
    begin
      rd_val[7:0] = q_ff.acc;
    end
    else if (i_araddr == OFS_INDEX)
    begin
      rd_val[15:0] = q_ff.index;
    end
    else if (i_araddr == OFS_LAST)
    begin
      rd_val[15:0] = q_ff.last;
    end
    else if (i_araddr == OFS_BUF_BASE)
    begin
      rd_val[7:0] = q_ff.buf_base;
    end
    else if (i_araddr == OFS_BUF_PTR)
    begin
      rd_val[7:0] = q_ff.buf_ptr;
    end
    else if (i_araddr == OFS_BUF_DATA)
    begin
      rd_val[7:0] = cmp_buf[q_ff.buf_ptr];
    end
    else
    begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.rx_go = 1'b0;
    nxt_q.tx_go = 1'b0;
    nxt_q.flash_rd = 1'b0;
    nxt_q.wd_pulse = 1'b0;
    buf_we = 1'b0;
    buf_waddr = cmp_idx;
    buf_wdata = i_flash_data;

    if (i_awvalid && o_awready)
    begin
      nxt_q.aw_held = 1'b1;
      nxt_q.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready)
    begin
      nxt_q.w_held = 1'b1;
      nxt_q.wdata = i_wdata;
      nxt_q.wstrb = i_wstrb;
    end
    if (q_ff.bvalid && i_bready)
    begin
      nxt_q.bvalid = 1'b0;
    end
    if (i_arvalid && o_arready)
    begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = rd_val;
      nxt_q.rresp = rd_resp;
    end
    else if (q_ff.rvalid && i_rready)
    begin
      nxt_q.rvalid = 1'b0;
    end

    if (wr_fire)
    begin
      nxt_q.aw_held = 1'b0;
      nxt_q.w_held = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = RESP_OKAY;
      if (wr_addr == OFS_CTRL)
      begin
        if (q_ff.wstrb[0] && !busy)
        begin
          if (wr_val[CTRL_RX_BIT])
          begin
            nxt_q.rx_go = 1'b1;
            nxt_q.mode = M_RX;
          end
          else if (wr_val[CTRL_TX_BIT])
          begin
            nxt_q.tx_go = 1'b1;
            nxt_q.tx_byte = q_ff.acc;
            nxt_q.mode = M_TX;
          end
          else if (wr_val[CTRL_VERIFY_BIT])
          begin
            nxt_q.send_opt = (q_ff.acc == 8'h00);
            nxt_q.sum = 8'h00;
            nxt_q.carry = 1'b1;
            nxt_q.offset = 8'h00;
            nxt_q.wd_cnt = 5'h00;
            nxt_q.wd_first_done = 1'b0;
            nxt_q.mode = M_VREAD;
          end
        end
      end
      else if (wr_addr == OFS_STATUS)
      begin
        if (q_ff.wstrb[0] && wr_val[ST_FRAME_BIT])
        begin
          nxt_q.frame_err = 1'b0;
        end
        if (q_ff.wstrb[0] && wr_val[ST_DONE_BIT])
        begin
          nxt_q.done = 1'b0;
        end
      end
      else if (wr_addr == OFS_ACC)
      begin
        if (q_ff.wstrb[0] && !busy)
        begin
          nxt_q.acc = wr_val[7:0];
        end
      end
      else if (wr_addr == OFS_INDEX)
      begin
        if (!busy)
        begin
          nxt_q.index[7:0] = q_ff.wstrb[0] ? wr_val[7:0] : q_ff.index[7:0];
          nxt_q.index[15:8] = q_ff.wstrb[1] ? wr_val[15:8] : q_ff.index[15:8];
        end
      end
      else if (wr_addr == OFS_LAST)
      begin
        if (!busy)
        begin
          nxt_q.last[7:0] = q_ff.wstrb[0] ? wr_val[7:0] : q_ff.last[7:0];
          nxt_q.last[15:8] = q_ff.wstrb[1] ? wr_val[15:8] : q_ff.last[15:8];
        end
      end
      else if (wr_addr == OFS_BUF_BASE)
      begin
        if (q_ff.wstrb[0] && !busy)
        begin
          nxt_q.buf_base = wr_val[7:0];
        end
      end
      else if (wr_addr == OFS_BUF_PTR)
      begin
        if (q_ff.wstrb[0])
        begin
          nxt_q.buf_ptr = wr_val[7:0];
        end
      end
      else if (wr_addr == OFS_BUF_DATA)
      begin
        if (q_ff.wstrb[0] && !busy)
        begin
          buf_we = 1'b1;
          buf_waddr = q_ff.buf_ptr;
          buf_wdata = wr_val[7:0];
          nxt_q.buf_ptr = q_ff.buf_ptr + 8'h01;
        end
      end
      else
      begin
        nxt_q.bresp = RESP_SLVERR;
      end
    end

    // The watchdog is serviced first at a fixed delay, then once per byte read.
    if ((q_ff.mode == M_VREAD || q_ff.mode == M_VCHECK || q_ff.mode == M_VSEND)
        && !q_ff.wd_first_done)
    begin
      nxt_q.wd_cnt = q_ff.wd_cnt + 5'h01;
      if (q_ff.wd_cnt == WD_FIRST_CYCLES - 5'h01)
      begin
        nxt_q.wd_pulse = 1'b1;
        nxt_q.wd_first_done = 1'b1;
      end
    end

    case (q_ff.mode)
      M_IDLE:
      begin
      end
      M_RX:
      begin
        if (char_done)
        begin
          nxt_q.acc = char_byte;
          nxt_q.carry = char_stop_ok;
          if (!char_stop_ok)
          begin
            nxt_q.frame_err = 1'b1;
          end
          nxt_q.done = 1'b1;
          nxt_q.mode = M_IDLE;
        end
      end
      M_TX:
      begin
        // Accumulator and index are left untouched by a transmit.
        if (char_done)
        begin
          nxt_q.done = 1'b1;
          nxt_q.mode = M_IDLE;
        end
      end
      M_VREAD:
      begin
        nxt_q.flash_rd = 1'b1;
        nxt_q.at_last = (q_ff.index == q_ff.last);
        nxt_q.mode = M_VCHECK;
      end
      M_VCHECK:
      begin
        nxt_q.sum = q_ff.sum + i_flash_data;
        nxt_q.index = q_ff.index + 16'h0001;
        if (q_ff.send_opt)
        begin
          nxt_q.tx_go = 1'b1;
          nxt_q.tx_byte = i_flash_data;
          nxt_q.mode = M_VSEND;
        end
        else
        begin
          if (cmp_buf[cmp_idx] != i_flash_data)
          begin
            nxt_q.carry = 1'b0;
          end
          buf_we = 1'b1;
          nxt_q.offset = q_ff.offset + 8'h01;
          if (q_ff.wd_first_done)
          begin
            nxt_q.wd_pulse = 1'b1;
          end
          if (q_ff.at_last)
          begin
            nxt_q.acc = nxt_q.sum;
            nxt_q.done = 1'b1;
            nxt_q.mode = M_IDLE;
          end
          else
          begin
            nxt_q.mode = M_VREAD;
          end
        end
      end
      M_VSEND:
      begin
        if (char_done)
        begin
          if (q_ff.wd_first_done)
          begin
            nxt_q.wd_pulse = 1'b1;
          end
          if (q_ff.at_last)
          begin
            nxt_q.acc = q_ff.sum;
            nxt_q.done = 1'b1;
            nxt_q.mode = M_IDLE;
          end
          else
          begin
            nxt_q.mode = M_VREAD;
          end
        end
      end
      default:
      begin
        nxt_q.mode = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      q_ff <= '0;
      q_ff.acc <= ACC_RST;
      q_ff.index <= INDEX_RST;
      q_ff.last <= LAST_RST;
      q_ff.buf_base <= BUF_BASE_RST;
    end
    else if (i_ce)
    begin
      q_ff <= nxt_q;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_ce && buf_we)
    begin
      cmp_buf[buf_waddr] <= buf_wdata;
    end
  end

  assign o_awready = !q_ff.aw_held && !q_ff.bvalid;
  assign o_wready = !q_ff.w_held && !q_ff.bvalid;
  assign o_bvalid = q_ff.bvalid;
  assign o_bresp = q_ff.bresp;
  assign o_arready = !q_ff.rvalid;
  assign o_rvalid = q_ff.rvalid;
  assign o_rdata = q_ff.rdata;
  assign o_rresp = q_ff.rresp;
  // The pin is open drain: data stays 0 and only the enable pulls it low.
  assign o_serial_pin = 1'b0;
  assign o_serial_pin_oe = char_drive_low;
  assign o_flash_addr = q_ff.index;
  assign o_flash_rd = q_ff.flash_rd;
  assign o_watchdog_service = q_ff.wd_pulse;
endmodule
`default_nettype wire

/* hw/psf_pkg.sv */
/*
  Shared constants for the single-pin serial link and the range read-back engine:
  bit timing, watchdog timing, register offsets, field positions and reset values.
  Assumes one clock that is also the operating clock the bit rate derives from.
*/
// Notes on behaviour
// - Receive captures one framed byte from the serial pin into the accumulator.
// - One bit lasts 256 operating clock cycles, for receive and transmit.
// - A missing high stop bit is reported as a framing error.
// - Carry set on good stop bit, cleared on framing error.
// - Receive waits without limit for a low start bit, then completes character.
// - Transmit sends the accumulator byte with the same framing and rate.
// - Transmit leaves accumulator and index register unchanged.
// - Verify picks send-out when accumulator is zero, else compare.
// - Send-out transmits each flash byte read at the transmit bit rate.
// - Compare checks each byte against buffer entry, then overwrites that entry.
// - Compare sets carry only if all bytes matched; send-out carry undefined.
// - Both options return low byte of sum of all bytes read.
// - Verify services watchdog, first service 24 bus cycles after call.
// - On exit index holds address just after last byte read.
// - Send-out neither reads nor writes the compare buffer.
`default_nettype none
package psf_pkg;
  localparam int BIT_DIV = 256;
  localparam int HALF_DIV = BIT_DIV / 2;
  localparam logic [3:0] DATA_BITS_LAST = 4'h7;
  localparam logic [3:0] FRAME_BITS_LAST = 4'h9;
  localparam logic [4:0] WD_FIRST_CYCLES = 5'h18;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_INDEX = 8'h0C;
  localparam logic [7:0] OFS_LAST = 8'h10;
  localparam logic [7:0] OFS_BUF_BASE = 8'h14;
  localparam logic [7:0] OFS_BUF_PTR = 8'h18;
  localparam logic [7:0] OFS_BUF_DATA = 8'h1C;
  localparam int CTRL_RX_BIT = 0;
  localparam int CTRL_TX_BIT = 1;
  localparam int CTRL_VERIFY_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CARRY_BIT = 1;
  localparam int ST_FRAME_BIT = 2;
  localparam int ST_DONE_BIT = 3;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] INDEX_RST = 16'h0000;
  localparam logic [15:0] LAST_RST = 16'h0000;
  localparam logic [7:0] BUF_BASE_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* hw/psf_char.sv */
/*
  Character engine for the shared open-drain serial pin: receives or sends one
  start/8-data/stop character. Assumes the pin is pulled up outside and that the
  pin input is synchronous to the clock.
*/
`default_nettype none
module psf_char #(
  parameter int BIT_DIV = psf_pkg::BIT_DIV
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_rx_go,
  input wire logic i_tx_go,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_pin,
  output logic o_done,
  output logic [7:0] o_byte,
  output logic o_stop_ok,
  output logic o_drive_low
);
  import psf_pkg::*;
  localparam int CW = $clog2(BIT_DIV);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_DIV - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(BIT_DIV / 2 - 1);

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_RX_WAIT = 3'b001,
    C_RX_START = 3'b010,
    C_RX_DATA = 3'b011,
    C_RX_STOP = 3'b100,
    C_TX = 3'b101
  } psf_char_state_t;

  typedef struct packed {
    psf_char_state_t state;
    logic [CW-1:0] cnt;
    logic [3:0] bitn;
    logic [9:0] shreg;
    logic drive_low;
    logic done;
    logic stop_ok;
  } psf_char_regs_t;

  psf_char_regs_t q_ff;
  psf_char_regs_t nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    case (q_ff.state)
      C_IDLE:
      begin
        if (i_rx_go)
        begin
          nxt_q.state = C_RX_WAIT;
        end
        else if (i_tx_go)
        begin
          nxt_q.shreg = {1'b1, i_tx_byte, 1'b0};
          nxt_q.cnt = BIT_LAST;
          nxt_q.bitn = 4'h0;
          nxt_q.drive_low = 1'b1;
          nxt_q.state = C_TX;
        end
      end
      C_RX_WAIT:
      begin
        if (!i_pin)
        begin
          nxt_q.cnt = HALF_LAST;
          nxt_q.state = C_RX_START;
        end
      end
      C_RX_START:
      begin
        if (q_ff.cnt != '0)
        begin
          nxt_q.cnt = q_ff.cnt - 1'b1;
        end
        else if (!i_pin)
        begin
          nxt_q.cnt = BIT_LAST;
          nxt_q.bitn = 4'h0;
          nxt_q.state = C_RX_DATA;
        end
        else
        begin
          // A glitch shorter than half a bit is not a start bit.
          nxt_q.state = C_RX_WAIT;
        end
      end
      C_RX_DATA:
      begin
        if (q_ff.cnt != '0)
        begin
          nxt_q.cnt = q_ff.cnt - 1'b1;
        end
        else
        begin
          nxt_q.shreg[7:0] = {i_pin, q_ff.shreg[7:1]};
          nxt_q.cnt = BIT_LAST;
          nxt_q.bitn = q_ff.bitn + 4'h1;
          if (q_ff.bitn == DATA_BITS_LAST)
          begin
            nxt_q.state = C_RX_STOP;
          end
        end
      end
      C_RX_STOP:
      begin
        if (q_ff.cnt != '0)
        begin
          nxt_q.cnt = q_ff.cnt - 1'b1;
        end
        else
        begin
          nxt_q.stop_ok = i_pin;
          nxt_q.done = 1'b1;
          nxt_q.state = C_IDLE;
        end
      end
      C_TX:
      begin
        if (q_ff.cnt != '0)
        begin
          nxt_q.cnt = q_ff.cnt - 1'b1;
        end
        else if (q_ff.bitn == FRAME_BITS_LAST)
        begin
          nxt_q.drive_low = 1'b0;
          nxt_q.stop_ok = 1'b1;
          nxt_q.done = 1'b1;
          nxt_q.state = C_IDLE;
        end
        else
        begin
          nxt_q.shreg = {1'b0, q_ff.shreg[9:1]};
          nxt_q.drive_low = ~q_ff.shreg[1];
          nxt_q.bitn = q_ff.bitn + 4'h1;
          nxt_q.cnt = BIT_LAST;
        end
      end
      default:
      begin
        nxt_q.state = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      q_ff <= '0;
    end
    else if (i_ce)
    begin
      q_ff <= nxt_q;
    end
  end

  assign o_done = q_ff.done;
  assign o_byte = q_ff.shreg[7:0];
  assign o_stop_ok = q_ff.stop_ok;
  assign o_drive_low = q_ff.drive_low;
endmodule
`default_nettype wire

/* dv/psf_top_assertions.sv */
/*
  Port checker for psf_top: bus handshakes, serial bit timing, read stepping.
  Assumes it is bound to psf_top and reaches its ports by name.
*/
`default_nettype none
module psf_top_assertions #(
  parameter int BIT_DIV = psf_pkg::BIT_DIV
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic o_serial_pin,
  input wire logic o_serial_pin_oe,
  input wire logic [15:0] o_flash_addr,
  input wire logic o_flash_rd,
  input wire logic o_watchdog_service
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run_ff;

  // Counts how long the device has been pulling the wire low.
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      run_ff <= 16'h0;
    else
      run_ff <= o_serial_pin_oe ? run_ff + 16'h1 : 16'h0;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  a_pin_zero:
    assert property (o_serial_pin == 1'h0) else $error("pin data bit not zero");
  a_bit_time:
    assert property ($fell(o_serial_pin_oe) |-> run_ff != 16'h0 && run_ff % BIT_DIV == 0
      && run_ff <= 9 * BIT_DIV) else $error("low drive is not whole bits");
  a_read_step:
    assert property (o_flash_rd |=> !o_flash_rd ##1 o_flash_addr == $past(o_flash_addr, 2)
      + 16'h1) else $error("read address did not step");
  a_wd_pulse:
    assert property (o_watchdog_service |=> !o_watchdog_service) else $error("long service");
  a_b_hold:
    assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_r_hold:
    assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data dropped");
  a_w_block:
    assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken early");
  a_r_block:
    assert property (o_rvalid |-> !o_arready) else $error("read taken early");
  a_r_lat:
    assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
  a_b_lat:
    assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write answer late");
endmodule
bind psf_top psf_top_assertions #(.BIT_DIV(BIT_DIV)) u_psf_top_assertions (.*);
`default_nettype wire

/* dv/psf_host.sv */
/*
  Host on the pulled-up serial wire: sends characters and decodes the device's.
  Assumes the bench resolves the wire level and feeds it to i_line.
*/
`default_nettype none
module psf_host #(
  parameter int BIT_DIV = 16
) (
  input wire logic i_clock,
  input wire logic i_line,
  output var logic o_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_byte;
  logic got_stop;
  event got;

  initial o_low = 1'h0;

  // A low stop bit makes a framing fault on purpose.
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      o_low <= !f[i];
      repeat (BIT_DIV) @(posedge i_clock);
    end
    o_low <= 1'h0;
  endtask

  always
  begin
    @(posedge i_clock iff (!i_line && !o_low));
    repeat (BIT_DIV / 2) @(posedge i_clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_DIV) @(posedge i_clock);
      got_byte[i] = i_line;
    end
    repeat (BIT_DIV) @(posedge i_clock);
    got_stop = i_line;
    ->got;
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
/*
  Self-checking bench for psf_top: bus master, flash model and serial host.
  Assumes psf_host and the checker are compiled before it.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psf_pkg::*;
  localparam int BD = 16;
  localparam int LIM = 400;
  typedef struct {logic [31:0] m; logic [31:0] v; logic [1:0] r;} psf_exp_t;
  logic i_clock = 1'h0;
  logic i_nrst = 1'h0;
  logic i_ce = 1'h1;
  logic [7:0] i_awaddr = 8'h0;
  logic [7:0] i_araddr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'h0;
  logic i_wvalid = 1'h0;
  logic i_bready = 1'h0;
  logic i_arvalid = 1'h0;
  logic i_rready = 1'h0;
  logic [7:0] i_flash_data;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_serial_pin_oe;
  logic o_serial_pin, o_flash_rd, o_watchdog_service, host_low;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, rdv;
  logic [15:0] o_flash_addr;
  wire logic i_serial_pin;
  psf_exp_t rq[$];
  psf_exp_t e;
  logic [1:0] bq[$];
  logic [8:0] sq[$];
  int errors = 0;
  int wd_n = 0;
  int total_checks = 0;

  function automatic logic [7:0] fl(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  psf_top #(.BIT_DIV(BD)) u_psf_top (.*);
  psf_host #(.BIT_DIV(BD)) u_psf_host (
    .i_clock(i_clock),
    .i_line(i_serial_pin),
    .o_low(host_low)
  );
  // Pulled-up wire: high unless a party pulls it low.
  assign i_serial_pin = !(o_serial_pin_oe && !o_serial_pin) && !host_low;
  always #25 i_clock = !i_clock;
  // Flash data stands only while the read strobe is high, so a late sample sees junk.
  always_comb
    i_flash_data = o_flash_rd ? fl(o_flash_addr) : ~fl(o_flash_addr);
  // Counts watchdog services, which a single character must never cause.
  always @(posedge i_clock)
    if (o_watchdog_service)
      wd_n++;

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (x !== g)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask

  task automatic lim(input int n);
    if (n >= LIM)
    begin
      $display("wait limit reached");
      errors++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    int dly;
    n = 0;
    dly = $urandom_range(3, 1);
    @(posedge i_clock);
    bq.push_back(r);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    do
    begin
      @(posedge i_clock);
      n++;
      if (o_awready)
        i_awvalid <= 1'h0;
      if (o_wready)
        i_wvalid <= 1'h0;
      if (n == dly)
        i_bready <= 1'h1;
    end while (!(o_bvalid && i_bready) && n < LIM);
    i_bready <= 1'h0;
    lim(n);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                    input logic [1:0] r = RESP_OKAY);
    int n;
    int dly;
    n = 0;
    dly = $urandom_range(3, 1);
    @(posedge i_clock);
    rq.push_back('{m, v, r});
    i_araddr <= a;
    i_arvalid <= 1'h1;
    do
    begin
      @(posedge i_clock);
      n++;
      if (o_arready)
        i_arvalid <= 1'h0;
      if (n == dly)
        i_rready <= 1'h1;
    end while (!(o_rvalid && i_rready) && n < LIM);
    rdv = o_rdata;
    i_rready <= 1'h0;
    lim(n);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      rd(OFS_STATUS, 32'h0, 32'h0);
      n++;
    end while (!rdv[ST_DONE_BIT] && n < LIM);
    lim(n);
  endtask

  always @(posedge i_clock)
  begin
    if (o_rvalid && i_rready)
    begin
      e = rq.pop_front();
      chk("rresp", 32'(e.r), 32'(o_rresp));
      if (e.m != 32'h0)
        chk("rdata", e.v, o_rdata & e.m);
    end
    if (o_bvalid && i_bready)
      chk("bresp", 32'(bq.pop_front()), 32'(o_bresp));
  end

  always @(u_psf_host.got)
    chk("serial", 32'(sq.pop_front()), {23'h0, u_psf_host.got_stop, u_psf_host.got_byte});

  initial
  begin
    repeat (100000) @(posedge i_clock);
    $display("run limit reached");
    errors++;
    conclude();
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] sum;
    logic [15:0] s;
    void'($urandom(24));
    repeat (3) @(posedge i_clock);
    i_nrst <= 1'h1;
    rd(OFS_ACC, 32'hFF, 32'(ACC_RST));
    rd(OFS_INDEX, 32'hFFFF, 32'(INDEX_RST));
    rd(OFS_STATUS, 32'hF, 32'h0);
    rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    repeat (2)
    begin
      d = 8'($urandom);
      s = 16'($urandom);
      wr(OFS_ACC, 32'(d));
      wr(OFS_INDEX, 32'(s));
      sq.push_back({1'h1, d});
      wr(OFS_CTRL, 32'h2);
      wait_done();
      rd(OFS_ACC, 32'hFF, 32'(d));
      rd(OFS_INDEX, 32'hFFFF, 32'(s));
      wr(OFS_STATUS, 32'hC);
    end
    for (int k = 0; k < 2; k++)
    begin
      d = 8'($urandom);
      wr(OFS_CTRL, 32'h1);
      repeat ($urandom_range(300, 20)) @(posedge i_clock);
      rd(OFS_STATUS, 32'h9, 32'h1);
      fork
        u_psf_host.send(d, 1'(k == 0));
      join_none
      wait_done();
      rd(OFS_ACC, k == 0 ? 32'hFF : 32'h0, 32'(d));
      rd(OFS_STATUS, 32'h6, k == 0 ? 32'h2 : 32'h4);
      wr(OFS_STATUS, 32'hC);
    end
    chk("watchdog", 32'h0, 32'(wd_n));
    s = 16'h12FE;
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_BUF_BASE, 32'h40);
      wr(OFS_BUF_PTR, 32'h40);
      sum = 8'h0;
      for (int i = 0; i < 4; i++)
      begin
        wr(OFS_BUF_DATA, 32'(fl(s + 16'(i)) ^ 8'(k == 1 && i == 2)));
        sum += fl(s + 16'(i));
      end
      wr(OFS_INDEX, 32'(s));
      wr(OFS_LAST, 32'(s + 16'h3));
      wr(OFS_ACC, 32'h55);
      wr(OFS_CTRL, 32'h4);
      wait_done();
      rd(OFS_ACC, 32'hFF, 32'(sum));
      rd(OFS_INDEX, 32'hFFFF, 32'(s + 16'h4));
      rd(OFS_STATUS, 32'h2, k == 0 ? 32'h2 : 32'h0);
      for (int i = 0; i < 4; i++)
      begin
        wr(OFS_BUF_PTR, 32'h40 + 32'(i));
        rd(OFS_BUF_DATA, 32'hFF, 32'(fl(s + 16'(i))));
      end
      wr(OFS_STATUS, 32'hC);
    end
    s = 16'($urandom);
    wr(OFS_INDEX, 32'(s));
    wr(OFS_LAST, 32'(s + 16'h1));
    wr(OFS_ACC, 32'h0);
    sq.push_back({1'h1, fl(s)});
    sq.push_back({1'h1, fl(s + 16'h1)});
    wr(OFS_CTRL, 32'h4);
    fork
      begin
        int n;
        n = 0;
        while (!o_watchdog_service && n < LIM)
        begin
          @(posedge i_clock);
          n++;
        end
        chk("service delay", 32'h1, 32'(n inside {23, 24}));
      end
    join_none
    wait_done();
    sum = fl(s) + fl(s + 16'h1);
    rd(OFS_ACC, 32'hFF, 32'(sum));
    rd(OFS_INDEX, 32'hFFFF, 32'(16'(s + 16'h2)));
    wr(OFS_BUF_PTR, 32'h40);
    rd(OFS_BUF_DATA, 32'hFF, 32'(fl(16'h12FE)));
    repeat (4 * BD) @(posedge i_clock);
    conclude();
  end
endmodule
`default_nettype wire
